// ===== common/crc_cmd_pkg.sv
// Constants, types and carriers for the flash CRC command handler
package crc_cmd_pkg;

  // Framing bytes and codes
  localparam logic [7:0] CMD_HEADER = 8'h01;
  localparam logic [7:0] REPLY_HEADER = 8'h81;
  localparam logic [7:0] TRAILER_BYTE = 8'h03;
  localparam logic [7:0] CMD_CRC = 8'h18;
  localparam logic [7:0] RESP_ERR = 8'h98;
  localparam logic [7:0] LEN_HIGH_ZERO = 8'h00;
  localparam logic [7:0] OK_LEN_LOW = 8'h05;
  localparam logic [7:0] ERR_LEN_LOW = 8'h0A;
  localparam logic [15:0] CMD_LEN = 16'h0009;
  localparam logic [15:0] FMT_LEN_MIN = 16'h0001;
  localparam logic [15:0] FMT_LEN_MAX = 16'h0400;

  // Status codes; values are arbitrary
  localparam logic [7:0] STATUS_PACKET = 8'hC1;
  localparam logic [7:0] STATUS_CHECKSUM = 8'hC2;
  localparam logic [7:0] STATUS_PARAM = 8'hC5;

  // Area information
  localparam logic [7:0] CONFIG_KIND = 8'h20;
  localparam int NUM_AREAS = 4;
  localparam int AREA_IDX_W = 2;

  // CRC and fill words
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] FILL_WORD = 32'hFFFFFFFF;

  // Buffer sizes and field positions
  localparam int CMD_BUF_LEN = 9;
  localparam int TX_BUF_LEN = 15;
  localparam logic [3:0] OK_PKT_LAST = 4'h9;
  localparam logic [3:0] ERR_PKT_LAST = 4'hE;
  localparam int START_POS = 1;
  localparam int END_POS = 5;

  typedef struct packed {
    logic [31:0] startAddr;
    logic [31:0] endAddr;
    logic [7:0] areaKind;
    logic [31:0] crcAccessUnit;
  } area_info_t;

  typedef struct packed {
    logic hit;
    logic [AREA_IDX_W-1:0] idx;
  } area_hit_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_beat_t;

endpackage : crc_cmd_pkg

// ===== design/flash_crc_command_handler.sv
// Flash CRC command: receive, check, compute CRC-32, reply
// Notes on behaviour
// - Waiting for a command, drop every byte until header 0x01 arrives.
// - Missing trailer 0x03 in last position answers packet error.
// - Checksum mismatch answers checksum error.
// - Length bytes bad in format or for this command answer packet error.
// - Any error skips processing and returns to waiting; flash untouched.
// - Start address above end address is a parameter error.
// - Address outside areas, or in different area kinds, is parameter error.
// - Zero CRC access unit of the area is a parameter error.
// - Start or end not aligned to the access unit is parameter error.
// - Config area kind 0x20 must be spanned exactly, else parameter error.
// - Only the highest-priority error is reported, in the listed order.
// - On pass, compute CRC over range, send result, return to waiting.
// - Success reply: 0x81, 0x00 0x05, 0x18, four result bytes, sum, trailer.
// - Result is sent most significant byte first.
// - Error reply: 0x81, 0x00 0x0A, 0x98, status, detail, address, sum, trailer.
// - Detail and failure address fields are all ones for every error.
// - CRC-32 by left shift, start all ones, polynomial 0x04C11DB7.
// - Flash bytes go into the CRC in ascending address order.
module flash_crc_command_handler
  import crc_cmd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Received byte stream
  input wire byte_beat_t rxBeat,
  // Reply byte stream
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  // Flash read port, one byte per handshake
  output logic flashRdReq,
  output logic [31:0] flashRdAddr,
  input wire logic flashRdValid,
  input wire logic [7:0] flashRdData,
  // Area information table
  input wire area_info_t [NUM_AREAS-1:0] areaInfo
);

  typedef enum logic [9:0] {
    S_WAIT = 10'b0000000001,
    S_LEN_HI = 10'b0000000010,
    S_LEN_LO = 10'b0000000100,
    S_BODY = 10'b0000001000,
    S_SUM = 10'b0000010000,
    S_TRAIL = 10'b0000100000,
    S_CHECK = 10'b0001000000,
    S_CRC = 10'b0010000000,
    S_SEND = 10'b0100000000,
    S_IDLE_PAD = 10'b1000000000
  } state_t;

  typedef logic [7:0] byte_t;

  function automatic logic [31:0] crcByte(input logic [31:0] crc,
                                          input byte_t b);
    logic [31:0] c;
    c = crc ^ {b, 24'h000000};
    for (int i = 0; i < 8; i++) begin
      c = c[31] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crcByte

  function automatic area_hit_t findArea(input logic [31:0] a,
      input area_info_t [NUM_AREAS-1:0] ar);
    area_hit_t r;
    r = '0;
    for (int i = NUM_AREAS - 1; i >= 0; i--) begin
      if (a >= ar[i].startAddr && a <= ar[i].endAddr) begin
        r.hit = 1'b1;
        r.idx = AREA_IDX_W'(i);
      end
    end
    return r;
  endfunction : findArea

  function automatic logic [31:0] getWord(
      input byte_t [CMD_BUF_LEN-1:0] b, input int pos);
    return {b[pos], b[pos+1], b[pos+2], b[pos+3]};
  endfunction : getWord

  // Reply checksum over length-high through last payload byte
  function automatic byte_t replySum(
      input byte_t [TX_BUF_LEN-1:0] b, input logic [3:0] last);
    byte_t s;
    s = 8'h00;
    for (int i = 1; i < TX_BUF_LEN - 2; i++) begin
      if (4'(i) < last - 4'h1) begin
        s = 8'(s + b[i]);
      end
    end
    return 8'(8'h00 - s);
  endfunction : replySum

  state_t state_q, state_d;
  logic [15:0] len_q, len_d;
  logic [15:0] bodyIdx_q, bodyIdx_d;
  byte_t [CMD_BUF_LEN-1:0] cmdBuf_q, cmdBuf_d;
  byte_t sumAcc_q, sumAcc_d;
  byte_t trailer_q, trailer_d;
  logic fmtBad_q, fmtBad_d;
  logic [31:0] addr_q, addr_d;
  logic [31:0] endAddr_q, endAddr_d;
  logic [31:0] crc_q, crc_d;
  byte_t [TX_BUF_LEN-1:0] txBuf_q, txBuf_d;
  logic [3:0] txIdx_q, txIdx_d;
  logic [3:0] txLast_q, txLast_d;

  // Parameter checks, read in S_CHECK only; lenLoByte is read in S_LEN_LO
  logic [31:0] reqStart, reqEnd, mask;
  area_hit_t hitS, hitE;
  area_info_t areaS;
  logic errTrail, errSum, errLen, errParam, isCrcCmd;
  byte_t errCode;
  logic [7:0] lenLoByte;

  always_comb begin
    reqStart = getWord(cmdBuf_q, START_POS);
    reqEnd = getWord(cmdBuf_q, END_POS);
    hitS = findArea(reqStart, areaInfo);
    hitE = findArea(reqEnd, areaInfo);
    areaS = areaInfo[hitS.idx];
    mask = 32'(areaS.crcAccessUnit - 32'h1);
    isCrcCmd = cmdBuf_q[0] == CMD_CRC;
    errTrail = trailer_q != TRAILER_BYTE;
    // Sum from length-high through checksum byte must be zero
    errSum = sumAcc_q != 8'h00;
    errLen = len_q != CMD_LEN;
    errParam = 1'b0;
    if (reqStart > reqEnd) begin
      errParam = 1'b1;
    end else if (!hitS.hit || !hitE.hit) begin
      errParam = 1'b1;
    end else if (areaS.areaKind != areaInfo[hitE.idx].areaKind) begin
      errParam = 1'b1;
    end else if (areaS.crcAccessUnit == 32'h0) begin
      errParam = 1'b1;
    end else if ((reqStart & mask) != 32'h0 ||
                 (32'(reqEnd + 32'h1) & mask) != 32'h0) begin
      errParam = 1'b1;
    end else if (areaS.areaKind == CONFIG_KIND &&
                 (reqStart != areaS.startAddr ||
                  reqEnd != areaS.endAddr)) begin
      errParam = 1'b1;
    end
    if (errTrail) begin
      errCode = STATUS_PACKET;
    end else if (errSum) begin
      errCode = STATUS_CHECKSUM;
    end else if (fmtBad_q || errLen) begin
      errCode = STATUS_PACKET;
    end else begin
      errCode = STATUS_PARAM;
    end
  end

  assign lenLoByte = rxBeat.data;
  assign txValid = state_q == S_SEND;
  assign txData = txBuf_q[txIdx_q];
  assign flashRdReq = state_q == S_CRC;
  assign flashRdAddr = addr_q;

  always_comb begin
    state_d = state_q;
    len_d = len_q;
    bodyIdx_d = bodyIdx_q;
    cmdBuf_d = cmdBuf_q;
    sumAcc_d = sumAcc_q;
    trailer_d = trailer_q;
    fmtBad_d = fmtBad_q;
    addr_d = addr_q;
    endAddr_d = endAddr_q;
    crc_d = crc_q;
    txBuf_d = txBuf_q;
    txIdx_d = txIdx_q;
    txLast_d = txLast_q;
    unique case (state_q)
      S_WAIT: begin
        if (rxBeat.valid && rxBeat.data == CMD_HEADER) begin
          state_d = S_LEN_HI;
          sumAcc_d = 8'h00;
          bodyIdx_d = 16'h0;
          cmdBuf_d = '0;
        end
      end
      S_LEN_HI: begin
        if (rxBeat.valid) begin
          len_d = {rxBeat.data, 8'h00};
          sumAcc_d = 8'(sumAcc_q + rxBeat.data);
          state_d = S_LEN_LO;
        end
      end
      S_LEN_LO: begin
        if (rxBeat.valid) begin
          len_d = {len_q[15:8], lenLoByte};
          sumAcc_d = 8'(sumAcc_q + rxBeat.data);
          fmtBad_d = {len_q[15:8], lenLoByte} < FMT_LEN_MIN ||
                     {len_q[15:8], lenLoByte} > FMT_LEN_MAX;
          state_d = fmtBad_d ? S_SUM : S_BODY;
        end
      end
      S_BODY: begin
        if (rxBeat.valid) begin
          // First CMD_BUF_LEN payload bytes kept in arrival order
          if (bodyIdx_q < 16'(CMD_BUF_LEN)) begin
            cmdBuf_d[bodyIdx_q] = rxBeat.data;
          end
          sumAcc_d = 8'(sumAcc_q + rxBeat.data);
          bodyIdx_d = 16'(bodyIdx_q + 16'h1);
          if (bodyIdx_d == len_q) begin
            state_d = S_SUM;
          end
        end
      end
      S_SUM: begin
        if (rxBeat.valid) begin
          sumAcc_d = 8'(sumAcc_q + rxBeat.data);
          state_d = S_TRAIL;
        end
      end
      S_TRAIL: begin
        if (rxBeat.valid) begin
          trailer_d = rxBeat.data;
          state_d = S_CHECK;
        end
      end
      S_CHECK: begin
        // Other commands belong to other handlers
        if (!errTrail && !errSum && !fmtBad_q && !isCrcCmd) begin
          state_d = S_WAIT;
        // Any error: reply and skip the flash walk
        end else if (errTrail || errSum || fmtBad_q || errLen ||
                     errParam) begin
          txBuf_d = '0;
          txBuf_d[0] = REPLY_HEADER;
          txBuf_d[1] = LEN_HIGH_ZERO;
          txBuf_d[2] = ERR_LEN_LOW;
          txBuf_d[3] = RESP_ERR;
          txBuf_d[4] = errCode;
          {txBuf_d[5], txBuf_d[6], txBuf_d[7], txBuf_d[8]} = FILL_WORD;
          {txBuf_d[9], txBuf_d[10], txBuf_d[11], txBuf_d[12]} = FILL_WORD;
          txBuf_d[13] = replySum(txBuf_d, ERR_PKT_LAST);
          txBuf_d[14] = TRAILER_BYTE;
          txLast_d = ERR_PKT_LAST;
          txIdx_d = 4'h0;
          state_d = S_SEND;
        end else begin
          addr_d = reqStart;
          endAddr_d = reqEnd;
          crc_d = CRC_INIT;
          state_d = S_CRC;
        end
      end
      S_CRC: begin
        if (flashRdValid) begin
          crc_d = crcByte(crc_q, flashRdData);
          addr_d = 32'(addr_q + 32'h1);
          if (addr_q == endAddr_q) begin
            txBuf_d = '0;
            txBuf_d[0] = REPLY_HEADER;
            txBuf_d[1] = LEN_HIGH_ZERO;
            txBuf_d[2] = OK_LEN_LOW;
            txBuf_d[3] = CMD_CRC;
            {txBuf_d[4], txBuf_d[5], txBuf_d[6], txBuf_d[7]} = crc_d;
            txBuf_d[8] = replySum(txBuf_d, OK_PKT_LAST);
            txBuf_d[9] = TRAILER_BYTE;
            txLast_d = OK_PKT_LAST;
            txIdx_d = 4'h0;
            state_d = S_SEND;
          end
        end
      end
      S_SEND: begin
        if (txReady) begin
          txIdx_d = 4'(txIdx_q + 4'h1);
          // Back to waiting after the last byte
          if (txIdx_q == txLast_q) begin
            txIdx_d = 4'h0;
            state_d = S_WAIT;
          end
        end
      end
      default: begin
        state_d = S_WAIT;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= S_WAIT;
      len_q <= 16'h0;
      bodyIdx_q <= 16'h0;
      cmdBuf_q <= '0;
      sumAcc_q <= 8'h00;
      trailer_q <= 8'h00;
      fmtBad_q <= 1'b0;
      addr_q <= 32'h0;
      endAddr_q <= 32'h0;
      crc_q <= CRC_INIT;
      txBuf_q <= '0;
      txIdx_q <= 4'h0;
      txLast_q <= 4'h0;
    end else begin
      state_q <= state_d;
      len_q <= len_d;
      bodyIdx_q <= bodyIdx_d;
      cmdBuf_q <= cmdBuf_d;
      sumAcc_q <= sumAcc_d;
      trailer_q <= trailer_d;
      fmtBad_q <= fmtBad_d;
      addr_q <= addr_d;
      endAddr_q <= endAddr_d;
      crc_q <= crc_d;
      txBuf_q <= txBuf_d;
      txIdx_q <= txIdx_d;
      txLast_q <= txLast_d;
    end
  end

endmodule : flash_crc_command_handler

// ===== bench/crc_cmd_chk.sv
// Port checker for the flash CRC command handler
module crc_cmd_chk
  import crc_cmd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Byte streams
  input wire byte_beat_t rxBeat,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txReady,
  // Flash port and areas
  input wire logic flashRdReq,
  input wire logic [31:0] flashRdAddr,
  input wire logic flashRdValid,
  input wire logic [7:0] flashRdData,
  input wire area_info_t [NUM_AREAS-1:0] areaInfo
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  reset_idle_a:
  assert property (disable iff (1'b0) reset |=> !txValid && !flashRdReq)
    else $error("busy after reset");
  walk_reply_excl_a:
  assert property (!(txValid && flashRdReq))
    else $error("flash read during reply");
  walk_ends_reply_a:
  assert property ($fell(flashRdReq) |-> $rose(txValid))
    else $error("walk ended without reply");
  reply_header_a:
  assert property ($rose(txValid) |-> txData == REPLY_HEADER)
    else $error("reply header wrong");
  len_high_a:
  assert property ($rose(txValid) && txReady |=> txData == LEN_HIGH_ZERO)
    else $error("length high wrong");
  len_low_a:
  assert property ($rose(txValid) && txReady ##1 txReady
    |=> txData inside {OK_LEN_LOW, ERR_LEN_LOW})
    else $error("length low wrong");
  reply_trailer_a:
  assert property ($fell(txValid) |-> $past(txData) == TRAILER_BYTE)
    else $error("reply not ended by trailer");
  tx_hold_a:
  assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("reply byte moved unaccepted");
  addr_hold_a:
  assert property (flashRdReq && !flashRdValid
    |=> flashRdReq && $stable(flashRdAddr))
    else $error("flash address moved early");
  addr_step_a:
  assert property (flashRdReq && flashRdValid
    |=> !flashRdReq || flashRdAddr == $past(flashRdAddr) + 32'h1)
    else $error("flash address not ascending");

  cover property ($rose(flashRdReq));
  cover property (txValid && txData == RESP_ERR);
  cover property ($fell(txValid));
endmodule : crc_cmd_chk

// ===== bench/flash_model.sv
// Flash array stand-in, one byte per read request
module flash_model (
  // Clock, reset and pace
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic slow,
  // Read port
  input wire logic rdReq,
  input wire logic [31:0] rdAddr,
  output logic rdValid,
  output logic [7:0] rdData
);
  logic [1:0] waitCnt = 2'h0;
  initial rdValid = 1'b0;
  initial rdData = 8'h5A;
  function automatic logic [7:0] memb(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : memb
  // Data toggles off the pulse so a stale byte never looks good
  always @(posedge ref_clk) begin
    if (reset || rdValid || !rdReq) begin
      rdValid <= 1'b0;
      rdData <= ~rdData;
      waitCnt <= 2'h0;
    end else if (waitCnt == (slow ? 2'h3 : 2'h0)) begin
      rdValid <= 1'b1;
      rdData <= memb(rdAddr);
    end else begin
      rdData <= ~rdData;
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule : flash_model

// ===== bench/tb.sv
// Testbench for the flash CRC command handler
module tb
  import crc_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  byte_beat_t rxBeat = '0;
  logic txReady = 1'b0;
  logic slow = 1'b0;
  logic txValid, flashRdReq, flashRdValid;
  logic [7:0] txData, flashRdData;
  logic [31:0] flashRdAddr, rs;
  area_info_t [NUM_AREAS-1:0] areas;
  int err_count = 0;
  int total_checks = 0;
  int rdCount = 0;

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (flashRdReq === 1'b1 && flashRdValid === 1'b1) rdCount++;

  flash_crc_command_handler i_dut (.ref_clk(ref_clk), .reset(reset),
    .rxBeat(rxBeat), .txValid(txValid), .txData(txData), .txReady(txReady),
    .flashRdReq(flashRdReq), .flashRdAddr(flashRdAddr),
    .flashRdValid(flashRdValid), .flashRdData(flashRdData), .areaInfo(areas));
  flash_model i_flash (.ref_clk(ref_clk), .reset(reset), .slow(slow),
    .rdReq(flashRdReq), .rdAddr(flashRdAddr), .rdValid(flashRdValid),
    .rdData(flashRdData));

  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  function automatic logic [31:0] crc_ref(input logic [31:0] s, e);
    logic [31:0] c;
    c = CRC_INIT;
    for (logic [31:0] a = s; a <= e; a++) begin
      c ^= {i_flash.memb(a), 24'h0};
      repeat (8) c = c[31] ? (c << 1) ^ CRC_POLY : c << 1;
    end
    return c;
  endfunction : crc_ref

  // Mode: 1 bad trailer and sum, 2 bad sum, 3 zero length, 4 short length
  // 5 foreign command code, dropped with no reply
  task automatic tcase(input logic [31:0] s, e, input logic [7:0] status,
                       input int m);
    logic [7:0] q[$];
    logic [7:0] x[$];
    logic [7:0] r[$];
    logic [7:0] sm;
    logic [31:0] c;
    int n0;
    int k;
    // Length, code, start then end address
    q = {8'h00, 8'h09, CMD_CRC, s[31:24], s[23:16], s[15:8], s[7:0],
         e[31:24], e[23:16], e[15:8], e[7:0]};
    if (m == 3) q = {8'h00, 8'h00};
    if (m == 4) begin
      q[1] = 8'h08;
      void'(q.pop_back());
    end
    if (m == 5) q[2] = 8'h17;
    sm = (m == 1 || m == 2) ? 8'h01 : 8'h00;
    // Sum of length through checksum is zero, one in modes 1 and 2
    foreach (q[i]) sm -= q[i];
    q.push_back(sm);
    q.push_back(m == 1 ? 8'h04 : TRAILER_BYTE);
    q.push_front(CMD_HEADER);
    c = crc_ref(s, e);
    if (status == 8'h00)
      x = {8'h00, OK_LEN_LOW, CMD_CRC, c[31:24], c[23:16], c[15:8], c[7:0]};
    else begin
      x = {8'h00, ERR_LEN_LOW, RESP_ERR, status};
      repeat (8) x.push_back(8'hFF);
    end
    sm = 8'h00;
    foreach (x[i]) sm -= x[i];
    x.push_back(sm);
    x.push_back(TRAILER_BYTE);
    x.push_front(REPLY_HEADER);
    if (m == 5) x.delete();
    n0 = rdCount;
    foreach (q[i]) begin
      @(posedge ref_clk);
      rxBeat <= {1'b1, q[i]};
      slow <= 1'($urandom);
    end
    @(posedge ref_clk);
    rxBeat <= '0;
    k = 0;
    // A dropped packet gets a quiet spell in which no byte may appear
    while ((r.size() < x.size() || m == 5) &&
           k < (m == 5 ? 300 : 4000)) begin
      @(posedge ref_clk);
      if (txValid === 1'b1 && txReady === 1'b1) r.push_back(txData);
      txReady <= 1'($urandom);
      k++;
    end
    chk(32'(r.size()), 32'(x.size()));
    foreach (x[i]) chk(32'(r[i]), 32'(x[i]));
    c = (status == 8'h00 && m != 5) ? e - s + 32'h1 : 32'h0;
    chk(32'(rdCount - n0), c);
    $display("case %h..%h mode %0d done", s, e, m);
  endtask : tcase

  initial begin
    #6000000;
    err_count++;
    complete_run();
  end

  initial begin
    areas[0] = '{32'h0, 32'hFFF, 8'h00, 32'h4};
    areas[1] = '{32'h0800_0000, 32'h0800_03FF, 8'h10, 32'h0};
    areas[2] = '{32'h0100_A100, 32'h0100_A11F, CONFIG_KIND, 32'h4};
    areas[3] = '{32'h1000, 32'h1FFF, 8'h01, 32'h10};
    void'($urandom(32'h7394));
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rxBeat <= {1'b1, 8'h03};
    tcase(32'h0, 32'hF, 8'h00, 0);
    tcase(32'h100, 32'h17F, 8'h00, 0);
    rs = 4 * ($urandom % 512);
    tcase(rs, rs + 4 * ($urandom % 16) + 3, 8'h00, 0);
    tcase(32'h0, 32'hF, STATUS_PACKET, 1);
    tcase(32'h0, 32'hF, STATUS_CHECKSUM, 2);
    tcase(32'h0, 32'hF, STATUS_PACKET, 3);
    tcase(32'h0, 32'hF, STATUS_PACKET, 4);
    tcase(32'h0, 32'hF, 8'h00, 5);
    tcase(32'h20, 32'h1F, STATUS_PARAM, 0);
    tcase(32'h0, 32'h4003, STATUS_PARAM, 0);
    tcase(32'hFF0, 32'h100F, STATUS_PARAM, 0);
    tcase(32'h0800_0000, 32'h0800_000F, STATUS_PARAM, 0);
    tcase(32'h2, 32'h11, STATUS_PARAM, 0);
    tcase(32'h0, 32'hE, STATUS_PARAM, 0);
    tcase(32'h0100_A100, 32'h0100_A10F, STATUS_PARAM, 0);
    tcase(32'h0100_A100, 32'h0100_A11F, 8'h00, 0);
    tcase(32'h1010, 32'h102F, 8'h00, 0);
    complete_run();
  end
endmodule : tb

bind flash_crc_command_handler crc_cmd_chk i_chk (.ref_clk(ref_clk),
  .reset(reset), .rxBeat(rxBeat), .txValid(txValid), .txData(txData),
  .txReady(txReady), .flashRdReq(flashRdReq), .flashRdAddr(flashRdAddr),
  .flashRdValid(flashRdValid), .flashRdData(flashRdData),
  .areaInfo(areaInfo));
